/* File: design/xbp_phase.sv */
/*
  bus cycle sequencer: address half, then data half, then idle.
  assumes start is a one-cycle pulse given only while idle.
*/
`timescale 1ns/1ps
`include "xbp_regs.svh"

module xbp_phase
(
  input wire logic clock_in,
  input wire logic rstn_in,
  xbp_phase_if.seq ph
);

  xbp_pkg::xbp_state_t state;
  xbp_pkg::xbp_state_t next_state;
  logic [1:0] cnt;
  logic [1:0] next_cnt;

  //////////////////////////////////////////////////////////////////////////////
  // next state: two clocks of address, then data clocks up to the last one
  always_comb
  begin
    next_state = state;
    next_cnt = cnt;
    case (state)
      xbp_pkg::XBP_IDLE:
      begin
        next_cnt = 2'h1;
        if (ph.start)
        begin
          next_state = xbp_pkg::XBP_ADDR;
        end
      end
      xbp_pkg::XBP_ADDR:
      begin
        next_cnt = cnt + 2'h1;
        if (cnt == `XBP_ADDR_CYCLES)
        begin
          next_state = xbp_pkg::XBP_DATA;
          next_cnt = 2'h0;
        end
      end
      xbp_pkg::XBP_DATA:
      begin
        next_cnt = cnt + 2'h1;
        if (cnt == `XBP_DATA_CYCLES)
        begin
          next_state = xbp_pkg::XBP_IDLE;
          next_cnt = 2'h1;
        end
      end
      default:
      begin
        next_state = xbp_pkg::XBP_IDLE;
        next_cnt = 2'h1;
      end
    endcase
  end

  // phase outputs; next_* let the pin flops line up with the state
  assign ph.idle = (state == xbp_pkg::XBP_IDLE);
  assign ph.next_addr = (next_state == xbp_pkg::XBP_ADDR);
  assign ph.next_data = (next_state == xbp_pkg::XBP_DATA);
  assign ph.last = (state == xbp_pkg::XBP_DATA) && (cnt == `XBP_DATA_CYCLES);

  // state registers
  always_ff @(posedge clock_in)
  begin
    if (!rstn_in)
    begin
      state <= xbp_pkg::XBP_IDLE;
      cnt <= 2'h1;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
    end
  end

endmodule

/* File: design/xbp_pins.sv */
/*
  pin logic of the external memory bus: address pins, shared address/data
  lines in four modes, address strobe, upper byte enable and first fetch address.
  assumes one request at a time from the core on clock_in; pins from outside
  are synchronised here.
*/
`timescale 1ns/1ps
`include "xbp_regs.svh"

module xbp_pins
(
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire logic req_in,
  input wire logic internal_in,
  input wire logic [23:0] addr_in,
  input wire logic write_in,
  input wire logic word_in,
  input wire logic bus16_in,
  input wire logic mux_in,
  input wire logic [15:0] wdata_in,
  input wire logic [7:0] int_bus_hi_in,
  input wire logic byte_enable_sel_in,
  input wire logic ext_fetch_n_in,
  input wire logic [15:0] shared_addr_data_lines_in,
  output logic busy_out,
  output logic done_out,
  output logic [15:0] rdata_out,
  output logic [23:0] boot_addr_out,
  output logic boot_ready_out,
  output logic [15:0] low_address_pins_out,
  output logic [3:0] upper_address_pins_out,
  output logic [15:0] shared_addr_data_lines_out,
  output logic [15:0] shared_addr_data_lines_oe_out,
  output logic addr_strobe_out,
  output logic upper_byte_enable_n_out
);

  xbp_phase_if ph ();

  xbp_phase u_phase
  (
    .clock_in(clock_in),
    .rstn_in(rstn_in),
    .ph(ph.seq)
  );

  //////////////////////////////////////////////////////////////////////////////
  // helpers

  // write data onto the lanes: odd byte high, even byte low on a 16-bit bus
  function automatic logic [15:0] lanes(input logic [15:0] w, input logic bus16,
                                        input logic word, input logic a0);
    if (!bus16 || word)
    begin
      lanes = bus16 ? w : {8'h00, w[7:0]};
    end
    else if (a0)
    begin
      lanes = {w[7:0], 8'h00};
    end
    else
    begin
      lanes = {8'h00, w[7:0]};
    end
  endfunction

  // upper byte enable: low for word or odd byte, 16-bit bus only
  function automatic logic upper_used(input logic bus16, input logic word,
                                      input logic a0);
    upper_used = bus16 && (word || a0);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // pin input synchronisers

  logic [15:0] lines_meta;
  logic [15:0] lines_sync;
  logic strap_meta;
  logic strap_sync;

  // two flops on every pin input
  always_ff @(posedge clock_in)
  begin
    lines_meta <= shared_addr_data_lines_in;
    lines_sync <= lines_meta;
    strap_meta <= ext_fetch_n_in;
    strap_sync <= strap_meta;
  end

  //////////////////////////////////////////////////////////////////////////////
  // request capture

  logic [19:0] c_addr;
  logic [15:0] c_wdata;
  logic c_write;
  logic c_word;
  logic c_bus16;
  logic c_mux;
  logic [19:0] next_c_addr;
  logic [15:0] next_c_wdata;
  logic next_c_write;
  logic next_c_word;
  logic next_c_bus16;
  logic next_c_mux;
  logic take;
  logic take_int;
  logic next_busy;
  logic next_done;
  logic [15:0] next_rdata;

  assign take = req_in && !busy_out && ph.idle && !internal_in;
  assign take_int = req_in && !busy_out && ph.idle && internal_in;
  assign ph.start = take;

  // latch the request; internal accesses finish at once with no pin activity
  always_comb
  begin
    next_c_addr = c_addr;
    next_c_wdata = c_wdata;
    next_c_write = c_write;
    next_c_word = c_word;
    next_c_bus16 = c_bus16;
    next_c_mux = c_mux;
    next_busy = busy_out;
    next_done = 1'b0;
    next_rdata = rdata_out;
    if (take)
    begin
      next_c_addr = addr_in[`XBP_EXT_ADDR_W-1:0];
      next_c_wdata = wdata_in;
      next_c_write = write_in;
      next_c_word = word_in;
      next_c_bus16 = bus16_in;
      next_c_mux = mux_in;
      next_busy = 1'b1;
    end
    else if (take_int)
    begin
      next_done = 1'b1;
    end
    if (ph.last)
    begin
      next_busy = 1'b0;
      next_done = 1'b1;
      if (!c_write)
      begin
        // pick the addressed lane, odd byte from the upper half on a 16-bit bus
        if (c_bus16 && c_word)
        begin
          next_rdata = lines_sync;
        end
        else if (c_bus16 && c_addr[0])
        begin
          next_rdata = {8'h00, lines_sync[15:8]};
        end
        else
        begin
          next_rdata = {8'h00, lines_sync[7:0]};
        end
      end
    end
  end

  // request registers
  always_ff @(posedge clock_in)
  begin
    if (!rstn_in)
    begin
      c_addr <= 20'h00000;
      c_wdata <= 16'h0000;
      c_write <= 1'b0;
      c_word <= 1'b0;
      c_bus16 <= 1'b0;
      c_mux <= 1'b0;
      busy_out <= 1'b0;
      done_out <= 1'b0;
      rdata_out <= 16'h0000;
    end
    else
    begin
      c_addr <= next_c_addr;
      c_wdata <= next_c_wdata;
      c_write <= next_c_write;
      c_word <= next_c_word;
      c_bus16 <= next_c_bus16;
      c_mux <= next_c_mux;
      busy_out <= next_busy;
      done_out <= next_done;
      rdata_out <= next_rdata;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // pin drivers, aligned with the sequencer state

  logic [15:0] next_low;
  logic [3:0] next_up;
  logic [15:0] next_out;
  logic [15:0] next_oe;
  logic next_strobe;
  logic next_ube_n;
  logic [15:0] wl;
  logic up;

  always_comb
  begin
    wl = lanes(next_c_wdata, next_c_bus16, next_c_word, next_c_addr[0]);
    up = upper_used(next_c_bus16, next_c_word, next_c_addr[0]);
    next_low = low_address_pins_out;
    next_up = upper_address_pins_out;
    next_out = 16'h0000;
    next_oe = 16'h0000;
    next_strobe = 1'b0;
    next_ube_n = 1'b1;
    if (ph.next_addr || ph.next_data)
    begin
      next_low = next_c_addr[15:0];
      next_up = next_c_addr[19:16];
      if (byte_enable_sel_in)
      begin
        next_ube_n = !up;
      end
      else
      begin
        next_ube_n = !(up && next_c_write && ph.next_data);
      end
    end
    if (ph.next_addr)
    begin
      // strobe for the first clock of the address half only
      next_strobe = ph.idle;
    end
    if (ph.next_addr && next_c_mux)
    begin
      next_out = next_c_addr[15:0];
      next_oe = 16'hffff;
    end
    else if ((ph.next_addr || ph.next_data) && next_c_bus16)
    begin
      next_out = wl;
      next_oe = next_c_write ? 16'hffff : 16'h0000;
    end
    else if (ph.next_addr || ph.next_data)
    begin
      if (next_c_mux)
      begin
        next_out = {next_c_addr[15:8], wl[7:0]};
      end
      else
      begin
        next_out = {int_bus_hi_in, wl[7:0]};
      end
      next_oe = {8'hff, next_c_write ? 8'hff : 8'h00};
    end
  end

  // pin registers
  always_ff @(posedge clock_in)
  begin
    if (!rstn_in)
    begin
      low_address_pins_out <= 16'h0000;
      upper_address_pins_out <= 4'h0;
      shared_addr_data_lines_out <= 16'h0000;
      shared_addr_data_lines_oe_out <= 16'h0000;
      addr_strobe_out <= 1'b0;
      upper_byte_enable_n_out <= 1'b1;
    end
    else
    begin
      low_address_pins_out <= next_low;
      upper_address_pins_out <= next_up;
      shared_addr_data_lines_out <= next_out;
      shared_addr_data_lines_oe_out <= next_oe;
      addr_strobe_out <= next_strobe;
      upper_byte_enable_n_out <= next_ube_n;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // first fetch address, taken from the strap after reset release

  logic [1:0] boot_cnt;
  logic [1:0] next_boot_cnt;
  logic [23:0] next_boot_addr;
  logic next_boot_ready;

  always_comb
  begin
    next_boot_cnt = boot_cnt;
    next_boot_addr = boot_addr_out;
    next_boot_ready = boot_ready_out;
    if (boot_cnt != `XBP_STRAP_WAIT)
    begin
      next_boot_cnt = boot_cnt + 2'h1;
    end
    else if (!boot_ready_out)
    begin
      next_boot_addr = strap_sync ? `XBP_BOOT_INT : `XBP_BOOT_EXT;
      next_boot_ready = 1'b1;
    end
  end

  // boot registers
  always_ff @(posedge clock_in)
  begin
    if (!rstn_in)
    begin
      boot_cnt <= 2'h0;
      boot_addr_out <= `XBP_BOOT_INT;
      boot_ready_out <= 1'b0;
    end
    else
    begin
      boot_cnt <= next_boot_cnt;
      boot_addr_out <= next_boot_addr;
      boot_ready_out <= next_boot_ready;
    end
  end

endmodule

/* File: inc/xbp_phase_if.sv */
/*
  phase signals from the bus cycle sequencer to the pin logic.
  assumes both ends run on the same clock.
*/
`timescale 1ns/1ps

interface xbp_phase_if;
  logic start;
  logic idle;
  logic next_addr;
  logic next_data;
  logic last;

  modport seq
  (
    input start,
    output idle,
    output next_addr,
    output next_data,
    output last
  );
  modport pins
  (
    output start,
    input idle,
    input next_addr,
    input next_data,
    input last
  );
endinterface

/* File: inc/xbp_pkg.sv */
/*
  types shared by the external bus pin block.
  assumes xbp_regs.svh is on the include path.
*/
package xbp_pkg;

  // bus cycle sequencer states, one-hot
  typedef enum logic [2:0] {
    XBP_IDLE = 3'b001,
    XBP_ADDR = 3'b010,
    XBP_DATA = 3'b100
  } xbp_state_t;

endpackage

/* File: inc/xbp_regs.svh */
/*
  timing counts, widths and reset values of the external bus pin block.
  assumes it is included by bare name from the design files.
*/
`ifndef XBP_REGS_SVH
`define XBP_REGS_SVH

// clocks spent in the address half, and last count (from 0) of the four-clock data half
`define XBP_ADDR_CYCLES 2'h2
`define XBP_DATA_CYCLES 2'h3
// widths of the internal and the external address
`define XBP_INT_ADDR_W 24
`define XBP_EXT_ADDR_W 20
// first fetch address after reset, internal and external memory
`define XBP_BOOT_INT 24'hff2080
`define XBP_BOOT_EXT 24'h0f2080
// clocks after reset release before the fetch strap is taken
`define XBP_STRAP_WAIT 2'h3

`endif

/* File: test/tb.sv */
/*
  testbench of the bus pin block.
  assumes the memory model and the bound checker.
*/
`timescale 1ns/1ps

module tb;
  logic clock_in, rstn_in, req_in, internal_in, write_in, word_in, bus16_in, mux_in;
  logic byte_enable_sel_in, ext_fetch_n_in, busy_out, done_out, boot_ready_out;
  logic addr_strobe_out, upper_byte_enable_n_out;
  logic [23:0] addr_in, boot_addr_out;
  logic [15:0] wdata_in, rdata_out, low_address_pins_out, shared_addr_data_lines_out;
  logic [15:0] shared_addr_data_lines_oe_out, shared_addr_data_lines_in, drv;
  logic [7:0] int_bus_hi_in;
  logic [3:0] upper_address_pins_out;
  int num_errors, samples_checked, ns, nu;
  logic [15:0] wv;
  // wire level from both drivers
  assign shared_addr_data_lines_in = (shared_addr_data_lines_oe_out
    & shared_addr_data_lines_out) | (~shared_addr_data_lines_oe_out & drv);
  xbp_pins dut_u (.*);
  xbp_mem_model mem_u
  (
    .clock_in(clock_in),
    .strobe_in(addr_strobe_out),
    .addr_in(low_address_pins_out),
    .drive_out(drv)
  );
  initial
  begin
    clock_in = 1'b0;
    forever #25 clock_in = ~clock_in;
  end
  ////////////////////////////////////////
  task chk(input logic ok, input string msg);
    samples_checked++;
    if (ok !== 1'b1)
    begin
      num_errors++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask
  task complete_run;
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task rst(input logic f);
    rstn_in = 1'b0;
    ext_fetch_n_in = f;
    repeat (6) @(negedge clock_in);
    rstn_in = 1'b1;
    repeat (6) @(negedge clock_in);
  endtask
  // one access; counts strobes until done
  task acc(input logic in, input logic [23:0] a, input logic wr, w, b);
    int n;
    n = 0;
    ns = 0;
    nu = 0;
    @(negedge clock_in);
    req_in = 1'b1;
    internal_in = in;
    addr_in = a;
    write_in = wr;
    word_in = w;
    bus16_in = b;
    @(negedge clock_in);
    req_in = 1'b0;
    while (done_out !== 1'b1 && n < 20)
    begin
      if (addr_strobe_out === 1'b1)
        ns++;
      // count byte enable cycles and keep a data half drive value
      if (upper_byte_enable_n_out === 1'b0)
        nu++;
      if (n == 5)
        wv = shared_addr_data_lines_out;
      @(negedge clock_in);
      n++;
    end
    if (n == 20)
    begin
      chk(1'b0, "no done");
      complete_run();
    end
  endtask
  function automatic logic [15:0] ex(input logic [23:0] a, input logic w, b);
    logic [15:0] d;
    d = {a[7:0] ^ 8'ha5, a[7:0]};
    if (b && w)
      return d;
    if (b && a[0])
      return {8'h00, d[15:8]};
    return {8'h00, d[7:0]};
  endfunction
  ////////////////////////////////////////
  task t_boot;
    rst(1'b1);
    chk(boot_ready_out === 1'b1 && boot_addr_out === 24'hff2080, "boot int");
    rst(1'b0);
    chk(boot_ready_out === 1'b1 && boot_addr_out === 24'h0f2080, "boot ext");
  endtask
  task t_modes;
    logic [23:0] a;
    for (int m = 0; m < 4; m++)
    begin
      mux_in = m[0];
      a = 24'hf3a5c6 + 24'(m);
      acc(1'b0, a, 1'b1, m[1], m[1]);
      chk(ns == 1, "strobe count");
      chk(wv === (m[1] ? 16'hc3e1 : {(m[0] ? a[15:8] : 8'h6b), 8'he1}), "write lanes");
      chk(nu == (m[1] ? 6 : 0), "word byte enable");
      acc(1'b0, a, 1'b0, m[1], m[1]);
      chk(rdata_out === ex(a, m[1], m[1]), "read data");
      chk(low_address_pins_out === a[15:0], "low pins");
      chk(upper_address_pins_out === 4'h3, "upper pins");
    end
  endtask
  task t_bytes;
    mux_in = 1'b1;
    for (int k = 0; k < 2; k++)
    begin
      acc(1'b0, 24'h012344 + 24'(k), 1'b0, 1'b0, 1'b1);
      chk(rdata_out === ex(24'h012344 + 24'(k), 1'b0, 1'b1), "byte lane");
      chk(nu == 6 * k, "byte enable byte");
    end
    byte_enable_sel_in = 1'b0;
    acc(1'b0, 24'h012345, 1'b1, 1'b0, 1'b1);
    chk(ns == 1, "write strobe mode");
    chk(nu == 4, "upper write strobe");
    chk(wv === 16'he100, "odd byte write lane");
    byte_enable_sel_in = 1'b1;
  endtask
  task t_internal;
    acc(1'b1, 24'hff2080, 1'b0, 1'b1, 1'b1);
    chk(ns == 0, "internal strobe");
  endtask
  initial
  begin
    num_errors = 0;
    samples_checked = 0;
    rstn_in = 1'b0;
    req_in = 1'b0;
    internal_in = 1'b0;
    write_in = 1'b0;
    word_in = 1'b0;
    bus16_in = 1'b0;
    mux_in = 1'b0;
    addr_in = 24'h000000;
    wdata_in = 16'hc3e1;
    int_bus_hi_in = 8'h6b;
    byte_enable_sel_in = 1'b1;
    ext_fetch_n_in = 1'b1;
    t_boot();
    t_modes();
    t_bytes();
    t_internal();
    complete_run();
  end
endmodule

/* File: test/xbp_chk_assertions.sv */
/*
  port checker of the bus pin block.
  assumes it is bound to xbp_pins.
*/
`timescale 1ns/1ps

module xbp_chk
(
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire logic req_in,
  input wire logic internal_in,
  input wire logic [23:0] addr_in,
  input wire logic write_in,
  input wire logic word_in,
  input wire logic bus16_in,
  input wire logic mux_in,
  input wire logic [15:0] wdata_in,
  input wire logic [7:0] int_bus_hi_in,
  input wire logic byte_enable_sel_in,
  input logic busy_out,
  input logic done_out,
  input logic [15:0] low_address_pins_out,
  input logic [3:0] upper_address_pins_out,
  input logic [15:0] shared_addr_data_lines_out,
  input logic [15:0] shared_addr_data_lines_oe_out,
  input logic addr_strobe_out,
  input logic upper_byte_enable_n_out
);
  logic [23:0] ca;
  logic [15:0] cw;
  logic cwd;
  wire tk = req_in && !busy_out && !internal_in;
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rstn_in);
  // capture of the taken request
  always_ff @(posedge clock_in)
  begin
    if (tk)
    begin
      ca <= addr_in;
      cw <= wdata_in;
      cwd <= word_in;
    end
  end
  ////////////////////////////////////////
  property p_stb_one;
    addr_strobe_out |=> !addr_strobe_out;
  endproperty
  a_stb_one: assert property (p_stb_one) else $error("strobe too long");
  property p_stb_take;
    tk |-> !addr_strobe_out ##1 addr_strobe_out;
  endproperty
  a_stb_take: assert property (p_stb_take) else $error("no strobe");
  property p_int;
    req_in && !busy_out && internal_in |-> ##1 done_out && !addr_strobe_out;
  endproperty
  a_int: assert property (p_int) else $error("internal access");
  property p_addr;
    tk |-> ##1 (low_address_pins_out == ca[15:0] && upper_address_pins_out == ca[19:16])[*6]
      ##1 done_out;
  endproperty
  a_addr: assert property (p_addr) else $error("address pins");
  property p_mux16;
    tk && mux_in && bus16_in |-> ##1 (shared_addr_data_lines_out == ca[15:0]
      && shared_addr_data_lines_oe_out == 16'hffff)[*2];
  endproperty
  a_mux16: assert property (p_mux16) else $error("mux16 address");
  property p_mux8;
    tk && mux_in && !bus16_in |-> ##1 (shared_addr_data_lines_out[15:8] == ca[15:8]
      && shared_addr_data_lines_oe_out[15:8] == 8'hff)[*6];
  endproperty
  a_mux8: assert property (p_mux8) else $error("mux8 upper");
  property p_dmx16;
    tk && !mux_in && bus16_in && write_in && word_in |-> ##1 (shared_addr_data_lines_out == cw
      && shared_addr_data_lines_oe_out == 16'hffff)[*6];
  endproperty
  a_dmx16: assert property (p_dmx16) else $error("demux16 data");
  property p_dmx8;
    tk && !mux_in && !bus16_in |-> ##1 (shared_addr_data_lines_out[15:8] == int_bus_hi_in
      && shared_addr_data_lines_oe_out[15:8] == 8'hff)[*6];
  endproperty
  a_dmx8: assert property (p_dmx8) else $error("demux8 upper");
  property p_ube;
    tk && bus16_in && byte_enable_sel_in |->
      ##1 (upper_byte_enable_n_out == !(cwd || ca[0]))[*6];
  endproperty
  a_ube: assert property (p_ube) else $error("byte enable");
endmodule

bind xbp_pins xbp_chk chk_u (.*);

/* File: test/xbp_mem_model.sv */
/*
  external memory model for the bus pin block.
  assumes it sees the strobe and low address pins on clock_in.
*/
`timescale 1ns/1ps

module xbp_mem_model
(
  input wire logic clock_in,
  input wire logic strobe_in,
  input wire logic [15:0] addr_in,
  output logic [15:0] drive_out
);
  logic [15:0] lat = 16'h0000;
  logic [2:0] cnt = 3'h0;
  logic flip = 1'b0;
  // latch the address on the strobe, answer for six clocks
  always_ff @(posedge clock_in)
  begin
    flip <= ~flip;
    if (strobe_in)
    begin
      lat <= addr_in;
      cnt <= 3'h6;
    end
    else if (cnt != 3'h0)
      cnt <= cnt - 3'h1;
  end
  // both bytes driven; a toggling pattern once released
  assign drive_out = (cnt != 3'h0) ? {lat[7:0] ^ 8'ha5, lat[7:0]} : {16{flip}};
endmodule
